/* File: rtl/pcm_pkg.sv */
/*
 Constants, types and decode helpers of the program-control core.
 Assumes a 16-bit byte address space and an 8-bit memory data path.
*/
`default_nettype none
package pcm_pkg;
   localparam logic [15:0] VEC_RESET    = 16'h0000;
   localparam logic [15:0] SHORT_TBL    = 16'h0040;
   localparam logic [15:0] OPTION_ADDR  = 16'h0080;
   localparam logic [15:0] PROTECT_ADDR = 16'h0081;
   localparam logic [15:0] ROM_BYTES    = 16'h1000;
   localparam logic [15:0] SFR_BASE     = 16'hFF00;
   localparam logic [15:0] RAM_BASE_SM  = 16'hFE80;
   localparam logic [15:0] RAM_BASE_LG  = 16'hFE00;
   localparam bit          RAM_LARGE    = 1'b1;
   localparam logic [15:0] RAM_BASE     = RAM_LARGE ? RAM_BASE_LG : RAM_BASE_SM;
   localparam logic [7:0]  RAM_OFS_MASK = RAM_LARGE ? 8'hFF : 8'h7F;
   localparam logic [15:0] SP_RESET     = 16'h0000;
   localparam logic [7:0]  FLAGS_RESET  = 8'h02;
   localparam logic [7:0]  FLAGS_FIXMSK = 8'h2E;
   localparam logic [7:0]  FLAGS_FIXVAL = 8'h02;
   localparam int          FL_IE        = 7;
   localparam int          FL_Z         = 6;
   localparam int          FL_AC        = 4;
   localparam int          FL_CY        = 0;
   localparam int          OPT_PORT_BIT = 0;
   localparam int          NUM_IRQ      = 13;
   localparam logic [12:0] MASK_RESET   = 13'h1FFF;
   localparam logic [7:0]  R_CMD        = 8'h00;
   localparam logic [7:0]  R_OPERAND    = 8'h04;
   localparam logic [7:0]  R_NEXT_FETCH = 8'h08;
   localparam logic [7:0]  R_FLAGS      = 8'h0C;
   localparam logic [7:0]  R_STACK      = 8'h10;
   localparam logic [7:0]  R_STATUS     = 8'h14;
   localparam logic [7:0]  R_IRQ_MASK   = 8'h18;
   localparam logic [7:0]  R_OPTION     = 8'h1C;
   localparam logic [7:0]  R_WORK       = 8'h20;

   typedef enum logic [4:0] {
      CMD_NOP, CMD_ADVANCE, CMD_BRANCH_IMM, CMD_BRANCH_REG, CMD_SHORT_CALL,
      CMD_PUSH_FLAGS, CMD_POP_FLAGS, CMD_RETURN_IRQ, CMD_IRQ_DISABLE,
      CMD_IRQ_ENABLE, CMD_ADD, CMD_SUB, CMD_ROTATE, CMD_BIT_LOAD,
      CMD_RAM_READ, CMD_SFR_READ, CMD_RAM_WRITE, CMD_SFR_WRITE
   } pcm_cmd_t;

   typedef enum logic [1:0] {RGN_ROM, RGN_RAM, RGN_SFR, RGN_NONE} pcm_rgn_t;

   typedef struct packed {
      logic       req;
      logic       we;
      pcm_rgn_t   rgn;
      logic [15:0] addr;
      logic [7:0] wdata;
   } pcm_mem_t;

   function automatic pcm_rgn_t region_of(input logic [15:0] a);
      if (a >= SFR_BASE)
         region_of = RGN_SFR;
      else if (a >= RAM_BASE)
         region_of = RGN_RAM;
      else if (a < ROM_BYTES)
         region_of = RGN_ROM;
      else
         region_of = RGN_NONE;
   endfunction

   // Slot 0014H has no source, so no index maps there
   function automatic logic [15:0] vec_of(input logic [3:0] i);
      case (i)
         4'h0:    vec_of = 16'h0006;
         4'h1:    vec_of = 16'h0008;
         4'h2:    vec_of = 16'h000A;
         4'h3:    vec_of = 16'h000C;
         4'h4:    vec_of = 16'h000E;
         4'h5:    vec_of = 16'h0010;
         4'h6:    vec_of = 16'h0012;
         4'h7:    vec_of = 16'h0016;
         4'h8:    vec_of = 16'h0018;
         4'h9:    vec_of = 16'h001A;
         4'hA:    vec_of = 16'h001C;
         4'hB:    vec_of = 16'h001E;
         default: vec_of = 16'h0020;
      endcase
   endfunction
endpackage
`default_nettype wire

/* File: rtl/pcm_core.sv */
/*
 Program-control core: next-fetch address, flag word, stack pointer,
 reset vectoring, interrupt entry and a Wishbone classic register slave.
 Assumes a memory that answers each request with a one-cycle ack.
*/
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Reset pin resets; power-on forces reset function
// - Oscillator pins pulled low during reset
// - One linear 64 KB address space
// - Vectors live in 0000H to 0021H
// - Vector low byte even, high byte odd
// - Fixed vector slot per interrupt source
// - Slot 0014H never used for vectoring
// - Short call reads table 0040H-007FH
// - Configuration byte read from 0080H
// - Protection byte read from 0081H
// - RAM 128 or 256 bytes, holds stack
// - Peripheral registers decoded at FF00H-FFFFH
// - Direct modes reach RAM and peripheral window
// - Fetch address advances by instruction length
// - Branch loads immediate or register value
// - Reset loads fetch address from 0000H/0001H
// - Reset sets flag word to 02H
// - Flags pushed and popped on stack
// - Flag bit layout with fixed bits
// - Enable clear blocks all interrupts
// - Enable set defers to source masks
// - Enable cleared by disable and acceptance
// - Zero flag follows zero result
// - Half-carry from bit 3 carry/borrow
// - Carry records overflow, rotate, bit ops
// - Stack pointer predecrement, postincrement
module pcm_core (
   input  wire logic        SYS_CLK_IN,       // 200 MHz clock
   input  wire logic        RST_B_IN,         // Sync reset, active low
   input  wire logic        RESET_PIN_B_IN,   // Shared reset/port pin
   input  wire logic        WB_CYC_IN,        // Bus cycle
   input  wire logic        WB_STB_IN,        // Bus strobe
   input  wire logic        WB_WE_IN,         // Bus write
   input  wire logic [7:0]  WB_ADR_IN,        // Byte address
   input  wire logic [3:0]  WB_SEL_IN,        // Byte lanes
   input  wire logic [31:0] WB_DAT_IN,        // Write data
   output logic      [31:0] WB_DAT_OUT,       // Read data
   output logic             WB_ACK_OUT,       // Bus ack
   output logic             MEM_REQ_OUT,      // Memory request
   output logic             MEM_WE_OUT,       // Memory write
   output logic      [1:0]  MEM_RGN_OUT,      // Address region
   output logic      [15:0] MEM_ADDR_OUT,     // Memory address
   output logic      [7:0]  MEM_WDATA_OUT,    // Memory write data
   input  wire logic [7:0]  MEM_RDATA_IN,     // Memory read data
   input  wire logic        MEM_ACK_IN,       // Memory ack pulse
   input  wire logic [12:0] IRQ_REQ_IN,       // Source requests
   output logic      [12:0] IRQ_ACK_OUT,      // Acceptance pulses
   output logic             OSC_IN_PULLDN_OUT,  // Osc input pulldown
   output logic             OSC_OUT_PULLDN_OUT, // Osc output pulldown
   output logic      [15:0] NEXT_FETCH_OUT,   // Next-fetch address
   output logic      [7:0]  FLAG_WORD_OUT     // Flag word
);
   typedef enum {
      ST_IDLE, ST_VEC_LO, ST_VEC_HI, ST_OPT, ST_PROT, ST_PUSH_PSW,
      ST_PUSH_PCH, ST_PUSH_PCL, ST_POP_PCL, ST_POP_PCH, ST_POP_PSW, ST_DATA
   } pcm_state_t;
   typedef enum {SEQ_BOOT, SEQ_IRQ, SEQ_CALL, SEQ_FLAGS, SEQ_RET} pcm_seq_t;

   pcm_state_t        state_q, state_d;
   pcm_seq_t          seq_q, seq_d;
   pcm_pkg::pcm_mem_t mem_q, mem_d;
   logic [15:0]       pc_q, pc_d;
   logic [15:0]       sp_q, sp_d;
   logic [15:0]       tbl_q, tbl_d;
   logic [15:0]       daddr_q, daddr_d;
   logic              dwe_q, dwe_d;
   logic [15:0]       operand_q, operand_d;
   logic [15:0]       work_q, work_d;
   logic [7:0]        psw_q, psw_d;
   logic [7:0]        save_q, save_d;
   logic [7:0]        opt_q, opt_d;
   logic [7:0]        prot_q, prot_d;
   logic [4:0]        cmd_q, cmd_d;
   logic [12:0]       mask_q, mask_d;
   logic [12:0]       iack_q, iack_d;
   logic              pin_en_q, pin_en_d;
   logic              pulldn_q, pulldn_d;
   logic [2:0]        pin_q, pin_d;
   logic              level_q, level_d;
   logic              ack_q, ack_d;
   logic [31:0]       dat_q, dat_d;

   logic        got, idle, wr, go, pin_rst, found;
   logic [7:0]  a, b, res;
   logic [8:0]  wide;
   logic [3:0]  idx;
   logic [12:0] pend;

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0]  sel);
      merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
   endfunction

   // Keeps fixed bits constant, used by bus writes and pops
   function automatic logic [7:0] fix_flags(input logic [7:0] v);
      fix_flags = (v & ~pcm_pkg::FLAGS_FIXMSK) | pcm_pkg::FLAGS_FIXVAL;
   endfunction

   function automatic logic [7:0] arith_flags(input logic [7:0] f,
                                              input logic [7:0] x,
                                              input logic [7:0] y,
                                              input logic [8:0] w);
      logic [7:0] t;
      t = f;
      t[pcm_pkg::FL_Z]  = (w[7:0] == 8'h00);
      t[pcm_pkg::FL_AC] = x[4] ^ y[4] ^ w[4];
      t[pcm_pkg::FL_CY] = w[8];
      arith_flags = t;
   endfunction

   always_comb
   begin
      state_d   = state_q;
      seq_d     = seq_q;
      pc_d      = pc_q;
      sp_d      = sp_q;
      tbl_d     = tbl_q;
      daddr_d   = daddr_q;
      dwe_d     = dwe_q;
      operand_d = operand_q;
      work_d    = work_q;
      psw_d     = psw_q;
      save_d    = save_q;
      opt_d     = opt_q;
      prot_d    = prot_q;
      cmd_d     = cmd_q;
      mask_d    = mask_q;
      pin_en_d  = pin_en_q;
      pulldn_d  = pulldn_q;
      iack_d    = 13'h0000;
      dat_d     = 32'h0000_0000;
      a         = operand_q[7:0];
      b         = operand_q[15:8];
      res       = 8'h00;
      wide      = 9'h000;
      idx       = 4'h0;
      found     = 1'b0;
      got       = mem_q.req & MEM_ACK_IN;
      idle      = (state_q == ST_IDLE);
      pin_d     = {pin_q[1:0], RESET_PIN_B_IN};
      level_d   = (pin_q[1] == pin_q[2]) ? pin_q[2] : level_q;
      pin_rst   = pin_en_q & ~level_q;
      ack_d     = WB_CYC_IN & WB_STB_IN & ~ack_q;
      wr        = ack_d & WB_WE_IN;
      go        = wr & idle & ~pin_rst & WB_SEL_IN[0]
                  & ({WB_ADR_IN[7:2], 2'b00} == pcm_pkg::R_CMD);

      // Register reads; unmapped addresses read zero
      if (ack_d & ~WB_WE_IN)
      begin
         if ({WB_ADR_IN[7:2], 2'b00} == pcm_pkg::R_CMD)
            dat_d = {27'h0, cmd_q};
         else if ({WB_ADR_IN[7:2], 2'b00} == pcm_pkg::R_OPERAND)
            dat_d = {16'h0, operand_q};
         else if ({WB_ADR_IN[7:2], 2'b00} == pcm_pkg::R_NEXT_FETCH)
            dat_d = {16'h0, pc_q};
         else if ({WB_ADR_IN[7:2], 2'b00} == pcm_pkg::R_FLAGS)
            dat_d = {24'h0, psw_q};
         else if ({WB_ADR_IN[7:2], 2'b00} == pcm_pkg::R_STACK)
            dat_d = {16'h0, sp_q};
         else if ({WB_ADR_IN[7:2], 2'b00} == pcm_pkg::R_STATUS)
            dat_d = {28'h0, pulldn_q, pin_en_q, level_q, ~idle};
         else if ({WB_ADR_IN[7:2], 2'b00} == pcm_pkg::R_IRQ_MASK)
            dat_d = {19'h0, mask_q};
         else if ({WB_ADR_IN[7:2], 2'b00} == pcm_pkg::R_OPTION)
            dat_d = {16'h0, prot_q, opt_q};
         else if ({WB_ADR_IN[7:2], 2'b00} == pcm_pkg::R_WORK)
            dat_d = {16'h0, work_q};
      end

      // Next-fetch, stack and flags may only be written while no sequence runs; operand and mask at any time
      if (wr)
      begin
         if ({WB_ADR_IN[7:2], 2'b00} == pcm_pkg::R_OPERAND)
            operand_d = merge16(operand_q, WB_DAT_IN, WB_SEL_IN);
         else if ({WB_ADR_IN[7:2], 2'b00} == pcm_pkg::R_IRQ_MASK)
            mask_d = 13'(merge16({3'b000, mask_q}, WB_DAT_IN, WB_SEL_IN));
         else if (idle && {WB_ADR_IN[7:2], 2'b00} == pcm_pkg::R_NEXT_FETCH)
            pc_d = merge16(pc_q, WB_DAT_IN, WB_SEL_IN);
         else if (idle && {WB_ADR_IN[7:2], 2'b00} == pcm_pkg::R_STACK)
            sp_d = merge16(sp_q, WB_DAT_IN, WB_SEL_IN);
         else if (idle && WB_SEL_IN[0] && {WB_ADR_IN[7:2], 2'b00} == pcm_pkg::R_FLAGS)
            psw_d = fix_flags(WB_DAT_IN[7:0]);
      end

      pend = IRQ_REQ_IN & ~mask_q;
      for (int i = pcm_pkg::NUM_IRQ - 1; i >= 0; i--)
      begin
         if (pend[i])
         begin
            found = 1'b1;
            idx   = 4'(i);
         end
      end

      if (go)
      begin
         cmd_d = WB_DAT_IN[4:0];
         case (pcm_pkg::pcm_cmd_t'(WB_DAT_IN[4:0]))
            pcm_pkg::CMD_ADVANCE:
               pc_d = pc_q + {13'h0000, operand_q[2:0]};
            pcm_pkg::CMD_BRANCH_IMM:
               pc_d = operand_q;
            pcm_pkg::CMD_BRANCH_REG:
               pc_d = work_q;
            pcm_pkg::CMD_SHORT_CALL:
            begin
               pc_d    = pc_q + 16'h0001;
               sp_d    = sp_q - 16'h0001;
               tbl_d   = pcm_pkg::SHORT_TBL | {10'h000, operand_q[4:0], 1'b0};
               seq_d   = SEQ_CALL;
               state_d = ST_PUSH_PCH;
            end
            pcm_pkg::CMD_PUSH_FLAGS:
            begin
               save_d  = psw_q;
               sp_d    = sp_q - 16'h0001;
               seq_d   = SEQ_FLAGS;
               state_d = ST_PUSH_PSW;
            end
            pcm_pkg::CMD_POP_FLAGS:
            begin
               seq_d   = SEQ_FLAGS;
               state_d = ST_POP_PSW;
            end
            pcm_pkg::CMD_RETURN_IRQ:
            begin
               seq_d   = SEQ_RET;
               state_d = ST_POP_PCL;
            end
            pcm_pkg::CMD_IRQ_DISABLE:
               psw_d[pcm_pkg::FL_IE] = 1'b0;
            pcm_pkg::CMD_IRQ_ENABLE:
               psw_d[pcm_pkg::FL_IE] = 1'b1;
            pcm_pkg::CMD_ADD:
            begin
               wide   = {1'b0, a} + {1'b0, b};
               psw_d  = arith_flags(psw_q, a, b, wide);
               work_d = {work_q[15:8], wide[7:0]};
            end
            pcm_pkg::CMD_SUB:
            begin
               wide   = {1'b0, a} - {1'b0, b};
               psw_d  = arith_flags(psw_q, a, b, wide);
               work_d = {work_q[15:8], wide[7:0]};
            end
            pcm_pkg::CMD_ROTATE:
            begin
               res                    = {a[6:0], a[7]};
               psw_d[pcm_pkg::FL_CY]  = a[7];
               work_d                 = {work_q[15:8], res};
            end
            pcm_pkg::CMD_BIT_LOAD:
               psw_d[pcm_pkg::FL_CY] = a[b[2:0]];
            pcm_pkg::CMD_RAM_READ, pcm_pkg::CMD_RAM_WRITE:
            begin
               daddr_d = pcm_pkg::RAM_BASE | {8'h00, a & pcm_pkg::RAM_OFS_MASK};
               dwe_d   = (WB_DAT_IN[4:0] == 5'(pcm_pkg::CMD_RAM_WRITE));
               state_d = ST_DATA;
            end
            pcm_pkg::CMD_SFR_READ, pcm_pkg::CMD_SFR_WRITE:
            begin
               daddr_d = pcm_pkg::SFR_BASE | {8'h00, a};
               dwe_d   = (WB_DAT_IN[4:0] == 5'(pcm_pkg::CMD_SFR_WRITE));
               state_d = ST_DATA;
            end
            default:
               cmd_d = WB_DAT_IN[4:0];
         endcase
      end
      else if (idle && !pin_rst && psw_q[pcm_pkg::FL_IE] && found)
      begin
         iack_d[idx]           = 1'b1;
         save_d                = psw_q;
         psw_d[pcm_pkg::FL_IE] = 1'b0;
         sp_d                  = sp_q - 16'h0001;
         tbl_d                 = pcm_pkg::vec_of(idx);
         seq_d                 = SEQ_IRQ;
         state_d               = ST_PUSH_PSW;
      end

      if (got)
      begin
         case (state_q)
            ST_PUSH_PSW:
               if (seq_q == SEQ_IRQ)
               begin
                  sp_d    = sp_q - 16'h0001;
                  state_d = ST_PUSH_PCH;
               end
               else
                  state_d = ST_IDLE;
            ST_PUSH_PCH:
            begin
               sp_d    = sp_q - 16'h0001;
               state_d = ST_PUSH_PCL;
            end
            ST_PUSH_PCL:
               state_d = ST_VEC_LO;
            ST_VEC_LO:
            begin
               pc_d[7:0] = MEM_RDATA_IN;
               state_d   = ST_VEC_HI;
            end
            ST_VEC_HI:
            begin
               pc_d[15:8] = MEM_RDATA_IN;
               state_d    = (seq_q == SEQ_BOOT) ? ST_OPT : ST_IDLE;
            end
            ST_OPT:
            begin
               opt_d    = MEM_RDATA_IN;
               pin_en_d = ~MEM_RDATA_IN[pcm_pkg::OPT_PORT_BIT];
               pulldn_d = 1'b0;
               state_d  = ST_PROT;
            end
            ST_PROT:
            begin
               prot_d  = MEM_RDATA_IN;
               state_d = ST_IDLE;
            end
            ST_POP_PCL:
            begin
               pc_d[7:0] = MEM_RDATA_IN;
               sp_d      = sp_q + 16'h0001;
               state_d   = ST_POP_PCH;
            end
            ST_POP_PCH:
            begin
               pc_d[15:8] = MEM_RDATA_IN;
               sp_d       = sp_q + 16'h0001;
               state_d    = ST_POP_PSW;
            end
            ST_POP_PSW:
            begin
               psw_d   = fix_flags(MEM_RDATA_IN);
               sp_d    = sp_q + 16'h0001;
               state_d = ST_IDLE;
            end
            ST_DATA:
            begin
               if (!dwe_q)
                  work_d = {work_q[7:0], MEM_RDATA_IN};
               state_d = ST_IDLE;
            end
            default:
               state_d = ST_IDLE;
         endcase
      end

      // Pin reset restarts the boot sequence while held
      if (pin_rst)
      begin
         state_d  = ST_VEC_LO;
         seq_d    = SEQ_BOOT;
         tbl_d    = pcm_pkg::VEC_RESET;
         psw_d    = pcm_pkg::FLAGS_RESET;
         pulldn_d = 1'b1;
         iack_d   = 13'h0000;
      end

      mem_d       = '0;
      mem_d.addr  = mem_q.addr;
      mem_d.req   = (state_d != ST_IDLE);
      case (state_d)
         ST_PUSH_PSW:
         begin
            mem_d.we    = 1'b1;
            mem_d.addr  = sp_d;
            mem_d.wdata = save_d;
         end
         ST_PUSH_PCH:
         begin
            mem_d.we    = 1'b1;
            mem_d.addr  = sp_d;
            mem_d.wdata = pc_d[15:8];
         end
         ST_PUSH_PCL:
         begin
            mem_d.we    = 1'b1;
            mem_d.addr  = sp_d;
            mem_d.wdata = pc_d[7:0];
         end
         ST_POP_PCL, ST_POP_PCH, ST_POP_PSW:
            mem_d.addr = sp_d;
         ST_VEC_LO:
            mem_d.addr = tbl_d;
         ST_VEC_HI:
            mem_d.addr = tbl_d + 16'h0001;
         ST_OPT:
            mem_d.addr = pcm_pkg::OPTION_ADDR;
         ST_PROT:
            mem_d.addr = pcm_pkg::PROTECT_ADDR;
         ST_DATA:
         begin
            mem_d.we    = dwe_d;
            mem_d.addr  = daddr_d;
            mem_d.wdata = b;
         end
         default:
            mem_d.req = 1'b0;
      endcase
      // One idle cycle after each ack keeps requests distinct
      if (got || pin_rst)
         mem_d.req = 1'b0;
      mem_d.rgn = pcm_pkg::region_of(mem_d.addr);
   end

   always_ff @(posedge SYS_CLK_IN)
   begin
      if (!RST_B_IN)
      begin
         state_q   <= ST_VEC_LO;
         seq_q     <= SEQ_BOOT;
         mem_q     <= '0;
         pc_q      <= 16'h0000;
         sp_q      <= pcm_pkg::SP_RESET;
         tbl_q     <= pcm_pkg::VEC_RESET;
         daddr_q   <= 16'h0000;
         dwe_q     <= 1'b0;
         operand_q <= 16'h0000;
         work_q    <= 16'h0000;
         psw_q     <= pcm_pkg::FLAGS_RESET;
         save_q    <= 8'h00;
         opt_q     <= 8'h00;
         prot_q    <= 8'h00;
         cmd_q     <= 5'h00;
         mask_q    <= pcm_pkg::MASK_RESET;
         iack_q    <= 13'h0000;
         pin_en_q  <= 1'b1;
         pulldn_q  <= 1'b1;
         pin_q     <= 3'b111;
         level_q   <= 1'b1;
         ack_q     <= 1'b0;
         dat_q     <= 32'h0000_0000;
      end
      else
      begin
         state_q   <= state_d;
         seq_q     <= seq_d;
         mem_q     <= mem_d;
         pc_q      <= pc_d;
         sp_q      <= sp_d;
         tbl_q     <= tbl_d;
         daddr_q   <= daddr_d;
         dwe_q     <= dwe_d;
         operand_q <= operand_d;
         work_q    <= work_d;
         psw_q     <= psw_d;
         save_q    <= save_d;
         opt_q     <= opt_d;
         prot_q    <= prot_d;
         cmd_q     <= cmd_d;
         mask_q    <= mask_d;
         iack_q    <= iack_d;
         pin_en_q  <= pin_en_d;
         pulldn_q  <= pulldn_d;
         pin_q     <= pin_d;
         level_q   <= level_d;
         ack_q     <= ack_d;
         dat_q     <= dat_d;
      end
   end

   assign WB_DAT_OUT         = dat_q;
   assign WB_ACK_OUT         = ack_q;
   assign MEM_REQ_OUT        = mem_q.req;
   assign MEM_WE_OUT         = mem_q.we;
   assign MEM_RGN_OUT        = mem_q.rgn;
   assign MEM_ADDR_OUT       = mem_q.addr;
   assign MEM_WDATA_OUT      = mem_q.wdata;
   assign IRQ_ACK_OUT        = iack_q;
   assign OSC_IN_PULLDN_OUT  = pulldn_q;
   assign OSC_OUT_PULLDN_OUT = pulldn_q;
   assign NEXT_FETCH_OUT     = pc_q;
   assign FLAG_WORD_OUT      = psw_q;
endmodule
`default_nettype wire

/* File: bench/pcm_mem_model.sv */
/* Memory beside the core: patterned ROM, RAM for stack and data.
 Assumes one request at a time, answered one cycle after it is seen. */
`timescale 1ns/1ps
`default_nettype none
module pcm_mem_model (
   input  wire logic        clk_in,    // Clock
   input  wire logic        req_in,    // Request
   input  wire logic        we_in,     // Write
   input  wire logic [15:0] addr_in,   // Address
   input  wire logic [7:0]  wdata_in,  // Write data
   output logic      [7:0]  rdata_out, // Read data
   output logic             ack_out    // Ack pulse
);
   logic [7:0] ram [256];
   always @(posedge clk_in)
   begin
      ack_out <= req_in && !ack_out;
      rdata_out <= ~rdata_out;  // Idle data keeps moving, never a stale byte
      if (req_in && !ack_out)
      begin
         if (we_in)
            ram[addr_in[7:0]] <= wdata_in;
         rdata_out <= addr_in[15] ? ram[addr_in[7:0]] : addr_in[7:0] ^ 8'hA5;
      end
   end
endmodule
`default_nettype wire

/* File: bench/pcm_core_chk.sv */
/* Port checker for the program-control core.
 Bound into every core instance; one clock, one reset. */
`timescale 1ns/1ps
`default_nettype none
module pcm_core_chk (
   input wire logic        SYS_CLK_IN,        // Clock
   input wire logic        RST_B_IN,          // Reset
   input wire logic        WB_CYC_IN,         // Cycle
   input wire logic        WB_ACK_OUT,        // Ack
   input wire logic        MEM_REQ_OUT,       // Request
   input wire logic [1:0]  MEM_RGN_OUT,       // Region
   input wire logic [15:0] MEM_ADDR_OUT,      // Address
   input wire logic        MEM_ACK_IN,        // Memory ack
   input wire logic [12:0] IRQ_ACK_OUT,       // Accepts
   input wire logic        OSC_IN_PULLDN_OUT, // Pulldown
   input wire logic [7:0]  FLAG_WORD_OUT      // Flags
);
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   a_bus_ack: assert property (WB_CYC_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
      else $error("bus ack missing");
   a_reset_flags: assert property ($rose(RST_B_IN) |-> FLAG_WORD_OUT == 8'h02)
      else $error("flags wrong after reset");
   a_reset_pulldn: assert property ($rose(RST_B_IN) |-> OSC_IN_PULLDN_OUT)
      else $error("pulldown off in reset");
   a_boot_fetch: assert property ($rose(RST_B_IN) |-> ##[0:3] MEM_REQ_OUT && MEM_ADDR_OUT == 16'h0000)
      else $error("no vector fetch");
   a_vec_pair: assert property (MEM_ACK_IN && MEM_REQ_OUT && MEM_ADDR_OUT == 16'h0000 |-> ##[1:4] MEM_REQ_OUT && MEM_ADDR_OUT == 16'h0001)
      else $error("vector high byte missing");
   a_req_drop: assert property (MEM_ACK_IN && MEM_REQ_OUT |=> !MEM_REQ_OUT)
      else $error("request held after ack");
   a_flag_fixed: assert property ((FLAG_WORD_OUT & 8'h2E) == 8'h02)
      else $error("fixed flag bits wrong");
   a_irq_gate: assert property (|IRQ_ACK_OUT |-> $past(FLAG_WORD_OUT[7]) && !FLAG_WORD_OUT[7])
      else $error("accept with enable low");
   a_irq_single: assert property ($onehot0(IRQ_ACK_OUT))
      else $error("two accepts at once");
   a_ram_region: assert property (MEM_REQ_OUT && MEM_ADDR_OUT[15:8] == 8'hFE |-> MEM_RGN_OUT == 2'd1)
      else $error("ram region wrong");
   c_irq: cover property (|IRQ_ACK_OUT);
   c_stack: cover property (MEM_REQ_OUT && MEM_RGN_OUT == 2'd1);
   c_boot: cover property (MEM_ACK_IN && MEM_ADDR_OUT == 16'h0001);
endmodule
bind pcm_core pcm_core_chk chk (.SYS_CLK_IN, .RST_B_IN, .WB_CYC_IN, .WB_ACK_OUT, .MEM_REQ_OUT,
   .MEM_RGN_OUT, .MEM_ADDR_OUT, .MEM_ACK_IN, .IRQ_ACK_OUT, .OSC_IN_PULLDN_OUT, .FLAG_WORD_OUT);
`default_nettype wire

/* File: bench/cpu_program_control_map_bench.sv */
/* Self-checking bench: Wishbone tasks drive commands, flags, stack, irq.
 Assumes the memory model's ROM pattern is address low byte XOR A5H. */
`timescale 1ns/1ps
`default_nettype none
module cpu_program_control_map_bench;
   logic        clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, we = 1'b0, ack, mreq, mwe, mack;
   logic [7:0]  adr = 8'h00, mrd, mwd, flags;
   logic [31:0] wdat = 32'h0, rdat, rd;
   logic [15:0] maddr, pc;
   logic [12:0] irq = 13'h0, iack;
   logic        pin_b = 1'b0, pdo;
   int          mismatches = 0, num_checks = 0;
   initial forever #2.5 clk = ~clk;
   pcm_core uut (.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .RESET_PIN_B_IN(pin_b), .WB_CYC_IN(cyc),
      .WB_STB_IN(cyc), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'h3), .WB_DAT_IN(wdat),
      .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .MEM_REQ_OUT(mreq), .MEM_WE_OUT(mwe),
      .MEM_RGN_OUT(), .MEM_ADDR_OUT(maddr), .MEM_WDATA_OUT(mwd), .MEM_RDATA_IN(mrd),
      .MEM_ACK_IN(mack), .IRQ_REQ_IN(irq), .IRQ_ACK_OUT(iack), .OSC_IN_PULLDN_OUT(),
      .OSC_OUT_PULLDN_OUT(pdo), .NEXT_FETCH_OUT(pc), .FLAG_WORD_OUT(flags));
   pcm_mem_model mem (.clk_in(clk), .req_in(mreq), .we_in(mwe), .addr_in(maddr),
      .wdata_in(mwd), .rdata_out(mrd), .ack_out(mack));
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Request held until ack is sampled; watchdog bounds the wait
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
   endtask
   task automatic idle();
      do wb(1'b0, 8'h14, 32'h0); while (rd[0] !== 1'b0);
   endtask
   task automatic cmd(input logic [15:0] op, input logic [4:0] c);
      wb(1'b1, 8'h04, {16'h0, op});
      wb(1'b1, 8'h00, {27'h0, c});
      idle();
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      #40000;
      mismatches++;
      results();
   end
   initial
   begin
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (20) @(posedge clk);
      wb(1'b0, 8'h14, 32'h0);
      chk("pin_reset", {pdo, rd[3:0]}, 5'h1D);
      pin_b <= 1'b1;
      idle();
      chk("next_fetch", pc, 16'hA4A5);
      chk("flags", flags, 8'h02);
      chk("pulldown", {pdo, rd[3]}, 2'b00);
      wb(1'b0, 8'h1C, 32'h0);
      chk("option", rd, 32'h2425);
      wb(1'b0, 8'h3C, 32'h0);
      chk("unmapped", rd, 32'h0);
      $display("boot test done");
      cmd(16'h0003, 5'd1);
      chk("advance", pc, 16'hA4A8);
      cmd(16'h2000, 5'd2);
      chk("branch", pc, 16'h2000);
      wb(1'b1, 8'h0C, 32'hFF);
      chk("flag_fixed", flags, 8'hD3);
      cmd(16'h0808, 5'd10);
      chk("half_carry", flags, 8'h92);
      cmd(16'h0505, 5'd11);
      chk("zero", flags, 8'hC2);
      $display("command test done");
      wb(1'b1, 8'h10, 32'hFF00);
      wb(1'b1, 8'h18, 32'h1F7F);
      irq <= 13'h0080;
      do @(posedge clk); while (iack === 13'h0);
      chk("irq_ack", iack, 13'h0080);
      chk("irq_flags", flags, 8'h42);
      irq <= 13'h0;
      idle();
      chk("irq_vector", pc, 16'hB2B3);
      wb(1'b0, 8'h10, 32'h0);
      chk("stack", rd, 32'hFEFD);
      cmd(16'h0, 5'd7);
      chk("ret_pc", pc, 16'h2000);
      chk("ret_flags", flags, 8'hC2);
      cmd(16'h0, 5'd8);
      irq <= 13'h0080;
      repeat (10) @(posedge clk);
      chk("irq_off", pc, 16'h2000);
      wb(1'b1, 8'h18, 32'h1FFF);
      cmd(16'h0, 5'd9);
      repeat (10) @(posedge clk);
      chk("irq_masked", flags, 8'hC2);
      irq <= 13'h0;
      cmd(16'h0001, 5'd4);
      chk("short_call", pc, 16'hE6E7);
      cmd(16'h0, 5'd5);
      wb(1'b1, 8'h0C, 32'h0);
      cmd(16'h0, 5'd6);
      chk("pop_flags", flags, 8'hC2);
      cmd(16'h5A10, 5'd16);
      cmd(16'h0010, 5'd14);
      wb(1'b0, 8'h20, 32'h0);
      chk("ram_data", rd, 32'h005A);
      $display("interrupt test done");
      results();
   end
endmodule
`default_nettype wire
